// ### hdl/scu_defines.svh
/*
  Register offsets, field positions, reset values and timing counts of the serial unit.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SCU_DEFINES_SVH
`define SCU_DEFINES_SVH
`define SCU_OFF_CTRL 12'h000
`define SCU_OFF_MODE 12'h004
`define SCU_OFF_STAT 12'h008
`define SCU_OFF_TXD 12'h00c
`define SCU_OFF_RXD 12'h010
`define SCU_OFF_PORT 12'h014
`define SCU_OFF_BAUD 12'h018
`define SCU_CTRL_TE 7
`define SCU_CTRL_RE 6
`define SCU_CTRL_CKHI 1
`define SCU_CTRL_CKLO 0
`define SCU_MODE_SYNC 0
`define SCU_MODE_PAR 1
`define SCU_MODE_SUBLP 2
`define SCU_MODE_CPUDIV2 3
`define SCU_ST_TXE 7
`define SCU_ST_RXF 6
`define SCU_ST_OVR 5
`define SCU_ST_FER 4
`define SCU_ST_PER 3
`define SCU_ST_TEND 2
`define SCU_PORT_DATA 0
`define SCU_PORT_DIR 1
`define SCU_OVERSAMPLE 5'd16
`define SCU_SAMPLE_EDGE 4'd8
`define SCU_BAUD_RST 16'h0003
`endif

// ### hdl/scu_pkg.sv
/*
  Types of the serial unit.
  Assumes scu_defines.svh is compiled alongside.
*/
package scu_pkg;
  typedef enum logic [1:0] {
    SCU_IDLE = 2'b00,
    SCU_START = 2'b01,
    SCU_DATA = 2'b10,
    SCU_STOP = 2'b11
  } scu_state_t;
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic tx_end;
  } scu_flags_t;
endpackage : scu_pkg

// ### hdl/scu_top.sv
/*
  Serial communication unit with AHB-Lite register slave, transmitter and receiver.
  Assumes one clock hclk and a single-master AHB-Lite bus; line inputs are asynchronous.
*/
// Local design decisions: the register offsets and register access over AHB-Lite.
// Behaviour
// - Writing transmit data clears empty flag; transfer to shifter sets it.
// - Transmit data writes always accepted; unsent earlier data overwritten.
// - Overrun sets overrun flag, keeps full flag, no transfer to data register.
// - Framing or parity error without overrun still transfers received frame.
// - Full flag unchanged by error frame; read after overrun clears it.
// - Receiver stops after break; no new start while framing flag set.
// - Clearing transmit enable resets transmitter, pin goes to port logic.
// - Synchronous mode: no transmit start while any receive error flag set.
// - Clearing receive enable leaves error flags unchanged.
// - Asynchronous receive uses 16x basic clock, syncs on start falling edge.
// - Each bit latched on 8th basic clock edge after sync edge.
// - At frame end full flag 0 means normal, 1 means overrun.
// - Reading receive data clears full flag; coinciding frame may be returned.
// - Clock pin leaving clock output drives low one system cycle.
// - In low-power subclock modes unit works only with CPU clock divided by two.
// - No reception while any error flag is set; full flag blocks only synchronous mode.
`timescale 1ns/10ps
`include "scu_defines.svh"
module scu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_in_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  input wire logic serial_clk_pin_i,
  output logic serial_clk_pin_o,
  output logic serial_clk_pin_oe
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [11:0] addr_r;
  logic [7:0] serial_control_reg_r;
  logic [3:0] serial_mode_reg_r;
  logic [1:0] port_reg_r;
  logic [15:0] baud_r;
  logic [7:0] tx_data_reg_r;
  logic [7:0] rx_data_reg_r;
  scu_pkg::scu_flags_t flg_r;
  scu_pkg::scu_flags_t rd_snap_r;
  logic take, wr_ctrl, wr_stat, wr_txd, rd_rxd;
  logic te, re, sync_m, usable;
  assign take = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_r && addr_r == `SCU_OFF_CTRL;
  assign wr_stat = wr_pend_r && addr_r == `SCU_OFF_STAT;
  assign wr_txd = wr_pend_r && addr_r == `SCU_OFF_TXD;
  assign rd_rxd = rd_pend_r && addr_r == `SCU_OFF_RXD;
  assign usable = !serial_mode_reg_r[`SCU_MODE_SUBLP] || serial_mode_reg_r[`SCU_MODE_CPUDIV2];
  assign te = serial_control_reg_r[`SCU_CTRL_TE] && usable;
  assign re = serial_control_reg_r[`SCU_CTRL_RE] && usable;
  assign sync_m = serial_mode_reg_r[`SCU_MODE_SYNC];

  function automatic logic [31:0] status_word(input scu_pkg::scu_flags_t f);
    status_word = {24'h000000, f.tx_empty_flag, f.rx_full_flag, f.overrun_flag,
                   f.framing_err_flag, f.parity_err_flag, f.tx_end, 2'b00};
  endfunction : status_word

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) addr_r <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        unique case ({haddr[11:2], 2'b00})
          `SCU_OFF_CTRL: hrdata <= {24'h000000, serial_control_reg_r};
          `SCU_OFF_MODE: hrdata <= {28'h0000000, serial_mode_reg_r};
          `SCU_OFF_STAT: hrdata <= status_word(flg_r);
          `SCU_OFF_RXD: hrdata <= {24'h000000, rx_data_reg_r};
          `SCU_OFF_PORT: hrdata <= {30'h00000000, port_reg_r};
          `SCU_OFF_BAUD: hrdata <= {16'h0000, baud_r};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_control_reg_r <= 8'h00;
      serial_mode_reg_r <= 4'h0;
      port_reg_r <= 2'b00;
      baud_r <= `SCU_BAUD_RST;
      tx_data_reg_r <= 8'h00;
    end else begin
      if (wr_ctrl) serial_control_reg_r <= hwdata[7:0];
      if (wr_pend_r && addr_r == `SCU_OFF_MODE) serial_mode_reg_r <= hwdata[3:0];
      if (wr_pend_r && addr_r == `SCU_OFF_PORT) port_reg_r <= hwdata[1:0];
      if (wr_pend_r && addr_r == `SCU_OFF_BAUD) baud_r <= hwdata[15:0];
      if (wr_txd) tx_data_reg_r <= hwdata[7:0];
    end
  end

  // Snapshot of flags seen by a status read, so a clear only hits flags read as 1.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_snap_r <= '0;
    end else if (take && !hwrite && {haddr[11:2], 2'b00} == `SCU_OFF_STAT) begin
      rd_snap_r <= flg_r;
    end else if (wr_stat) begin
      rd_snap_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Line inputs and baud tick
  // ----------------------------------------------------------------
  logic [2:0] rxs_r, cks_r;
  logic rx_lvl_r, ck_lvl_r;
  logic [15:0] bdiv_r;
  logic tick16;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxs_r <= 3'b111;
      cks_r <= 3'b111;
      rx_lvl_r <= 1'b1;
      ck_lvl_r <= 1'b1;
    end else begin
      rxs_r <= {rxs_r[1:0], serial_in_pin};
      cks_r <= {cks_r[1:0], serial_clk_pin_i};
      if (rxs_r[2] == rxs_r[1]) rx_lvl_r <= rxs_r[2];
      if (cks_r[2] == cks_r[1]) ck_lvl_r <= cks_r[2];
    end
  end
  assign tick16 = bdiv_r == 16'h0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bdiv_r <= 16'h0000;
    end else begin
      bdiv_r <= tick16 ? baud_r : bdiv_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter and serial clock output
  // ----------------------------------------------------------------
  scu_pkg::scu_state_t tx_st_r;
  logic [7:0] tx_shift_reg_r;
  logic [3:0] tx_ph_r;
  logic [2:0] tx_bit_r;
  logic tx_line_r, sck_r, ck_was_r;
  logic ck_out_en, any_err, tx_load, tx_bit_end;
  assign any_err = flg_r.overrun_flag || flg_r.framing_err_flag || flg_r.parity_err_flag;
  assign ck_out_en = sync_m && !serial_control_reg_r[`SCU_CTRL_CKHI];
  assign tx_bit_end = tick16 && tx_ph_r == 4'hf;
  assign tx_load = te && !flg_r.tx_empty_flag && !(sync_m && any_err) &&
                   (tx_st_r == scu_pkg::SCU_IDLE || (tx_st_r == scu_pkg::SCU_STOP && tx_bit_end));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_r <= scu_pkg::SCU_IDLE;
      tx_shift_reg_r <= 8'h00;
      tx_ph_r <= 4'h0;
      tx_bit_r <= 3'd0;
      tx_line_r <= 1'b1;
      sck_r <= 1'b1;
    end else if (!te) begin
      tx_st_r <= scu_pkg::SCU_IDLE;
      tx_ph_r <= 4'h0;
      tx_bit_r <= 3'd0;
      tx_line_r <= 1'b1;
      sck_r <= 1'b1;
    end else begin
      if (tick16) tx_ph_r <= tx_ph_r + 4'h1;
      sck_r <= (tx_st_r == scu_pkg::SCU_DATA) ? !tx_ph_r[3] : 1'b1;
      if (tx_load) begin
        tx_shift_reg_r <= tx_data_reg_r;
        tx_ph_r <= 4'h0;
        tx_bit_r <= 3'd0;
        tx_st_r <= sync_m ? scu_pkg::SCU_DATA : scu_pkg::SCU_START;
        tx_line_r <= sync_m ? tx_data_reg_r[0] : 1'b0;
      end else if (tx_bit_end) begin
        unique case (tx_st_r)
          scu_pkg::SCU_IDLE: tx_line_r <= 1'b1;
          scu_pkg::SCU_START: begin
            tx_st_r <= scu_pkg::SCU_DATA;
            tx_line_r <= tx_shift_reg_r[0];
          end
          scu_pkg::SCU_DATA: begin
            tx_bit_r <= tx_bit_r + 3'd1;
            tx_shift_reg_r <= {1'b0, tx_shift_reg_r[7:1]};
            tx_line_r <= (tx_bit_r == 3'd7) ? 1'b1 : tx_shift_reg_r[1];
            if (tx_bit_r == 3'd7) begin
              tx_st_r <= sync_m ? scu_pkg::SCU_IDLE : scu_pkg::SCU_STOP;
            end
          end
          scu_pkg::SCU_STOP: begin
            tx_st_r <= scu_pkg::SCU_IDLE;
            tx_line_r <= 1'b1;
          end
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      serial_clk_pin_o <= 1'b1;
      serial_clk_pin_oe <= 1'b0;
      ck_was_r <= 1'b0;
    end else begin
      serial_out_pin_o <= te ? tx_line_r : port_reg_r[`SCU_PORT_DATA];
      serial_out_pin_oe <= te ? 1'b1 : port_reg_r[`SCU_PORT_DIR];
      ck_was_r <= ck_out_en;
      serial_clk_pin_o <= ck_out_en ? sck_r : !ck_was_r;
      serial_clk_pin_oe <= ck_out_en || ck_was_r;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  scu_pkg::scu_state_t rx_st_r;
  logic [7:0] rx_shift_reg_r;
  logic [3:0] rx_ph_r;
  logic [2:0] rx_bit_r;
  logic rx_prev_r, ck_prev_r, rx_par_r;
  logic rx_blocked, rx_samp, rx_done, rx_fer, rx_per;
  assign rx_blocked = flg_r.rx_full_flag || any_err;
  assign rx_samp = sync_m ? (ck_lvl_r && !ck_prev_r) : (tick16 && rx_ph_r == `SCU_SAMPLE_EDGE - 4'd1);
  assign rx_done = rx_samp && ((sync_m && rx_st_r == scu_pkg::SCU_DATA && rx_bit_r == 3'd7) ||
                   rx_st_r == scu_pkg::SCU_STOP);
  assign rx_fer = !sync_m && !rx_lvl_r;
  assign rx_per = !sync_m && serial_mode_reg_r[`SCU_MODE_PAR] && rx_par_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r <= scu_pkg::SCU_IDLE;
      rx_shift_reg_r <= 8'h00;
      rx_ph_r <= 4'h0;
      rx_bit_r <= 3'd0;
      rx_prev_r <= 1'b1;
      ck_prev_r <= 1'b1;
      rx_par_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_lvl_r;
      ck_prev_r <= ck_lvl_r;
      if (tick16) rx_ph_r <= rx_ph_r + 4'h1;
      if (!re) begin
        rx_st_r <= scu_pkg::SCU_IDLE;
      end else if (rx_st_r == scu_pkg::SCU_IDLE) begin
        rx_bit_r <= 3'd0;
        rx_par_r <= 1'b0;
        if (!sync_m && !any_err && rx_prev_r && !rx_lvl_r) begin
          rx_ph_r <= 4'h0;
          rx_st_r <= scu_pkg::SCU_START;
        end else if (sync_m && !rx_blocked) begin
          rx_st_r <= scu_pkg::SCU_DATA;
        end
      end else if (rx_samp) begin
        unique case (rx_st_r)
          scu_pkg::SCU_START: rx_st_r <= rx_lvl_r ? scu_pkg::SCU_IDLE : scu_pkg::SCU_DATA;
          scu_pkg::SCU_DATA: begin
            rx_shift_reg_r <= {rx_lvl_r, rx_shift_reg_r[7:1]};
            rx_par_r <= rx_par_r ^ rx_lvl_r;
            rx_bit_r <= rx_bit_r + 3'd1;
            if (rx_bit_r == 3'd7) begin
              rx_st_r <= sync_m ? scu_pkg::SCU_IDLE : scu_pkg::SCU_STOP;
            end
          end
          scu_pkg::SCU_STOP: rx_st_r <= scu_pkg::SCU_IDLE;
          default: rx_st_r <= scu_pkg::SCU_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flg_r <= '{tx_empty_flag: 1'b1, rx_full_flag: 1'b0, overrun_flag: 1'b0,
                 framing_err_flag: 1'b0, parity_err_flag: 1'b0, tx_end: 1'b1};
      rx_data_reg_r <= 8'h00;
    end else begin
      if (wr_txd) begin
        flg_r.tx_empty_flag <= 1'b0;
        flg_r.tx_end <= 1'b0;
      end else if (tx_load) begin
        flg_r.tx_empty_flag <= 1'b1;
      end else if (tx_bit_end && flg_r.tx_empty_flag &&
                   (tx_st_r == scu_pkg::SCU_STOP || (sync_m && tx_st_r == scu_pkg::SCU_DATA && tx_bit_r == 3'd7))) begin
        flg_r.tx_end <= 1'b1;
      end
      if (rd_rxd) flg_r.rx_full_flag <= 1'b0;
      if (wr_stat) begin
        if (rd_snap_r.overrun_flag && !hwdata[`SCU_ST_OVR]) flg_r.overrun_flag <= 1'b0;
        if (rd_snap_r.framing_err_flag && !hwdata[`SCU_ST_FER]) flg_r.framing_err_flag <= 1'b0;
        if (rd_snap_r.parity_err_flag && !hwdata[`SCU_ST_PER]) flg_r.parity_err_flag <= 1'b0;
        if (rd_snap_r.rx_full_flag && !hwdata[`SCU_ST_RXF]) flg_r.rx_full_flag <= 1'b0;
      end
      if (rx_done) begin
        if (flg_r.rx_full_flag && !rd_rxd) begin
          flg_r.overrun_flag <= 1'b1;
          flg_r.rx_full_flag <= 1'b1;
        end else begin
          rx_data_reg_r <= rx_shift_reg_r;
          if (rx_fer || rx_per) begin
            flg_r.rx_full_flag <= flg_r.rx_full_flag && !rd_rxd;
          end else begin
            flg_r.rx_full_flag <= 1'b1;
          end
        end
        if (rx_fer) flg_r.framing_err_flag <= 1'b1;
        if (rx_per) flg_r.parity_err_flag <= 1'b1;
      end
    end
  end
endmodule : scu_top

// ### verif/scu_top_asserts.sv
/*
  Port checker for the serial unit, bound to scu_top.
  Assumes single-master AHB-Lite with hready tied to hreadyout.
*/
`timescale 1ns/10ps
`include "scu_defines.svh"
module scu_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe,
  input wire logic serial_clk_pin_i,
  input wire logic serial_clk_pin_o,
  input wire logic serial_clk_pin_oe
);
  // ----------
  // Shadow of the configuration
  // ----------
  logic av_r, aw_r, wr, st, te;
  logic [11:0] aa_r;
  logic [7:0] ctrl_r, mode_r, port_r;
  logic [2:0] age_r;
  assign wr = av_r && aw_r && hready;
  assign st = age_r >= 3'h3;
  assign te = ctrl_r[`SCU_CTRL_TE] && !(mode_r[2] && !mode_r[3]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {av_r, aw_r, aa_r, ctrl_r, mode_r, port_r} <= '0;
    end else begin
      if (hready) begin
        {av_r, aw_r, aa_r} <= {hsel && htrans[1], hwrite, haddr};
      end
      if (wr && aa_r == `SCU_OFF_CTRL) ctrl_r <= hwdata[7:0];
      if (wr && aa_r == `SCU_OFF_MODE) mode_r <= hwdata[7:0];
      if (wr && aa_r == `SCU_OFF_PORT) port_r <= hwdata[7:0];
    end
  end
  // Pins lag a write by a register stage, so checks wait until it has settled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) age_r <= 3'h0;
    else if (wr) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_HREADY: assert property (hreadyout) else $error("wait state inserted");
  AST_HRESP: assert property (!hresp) else $error("error response seen");
  AST_UNMAPPED: assert property (hsel && hready && htrans[1] && !hwrite && haddr >= 12'h01c
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_TX_ON: assert property (st && te |-> serial_out_pin_oe) else $error("line not driven");
  AST_TX_DIR: assert property (st && !te |-> serial_out_pin_oe == port_r[1])
    else $error("line direction not from port");
  AST_TX_LVL: assert property (st && !te && port_r[1] |-> serial_out_pin_o == port_r[0])
    else $error("line level not from port");
  AST_SUBLP: assert property (st && mode_r[2] && !mode_r[3] && !port_r[1]
    |-> !serial_out_pin_oe) else $error("transmit active in low-power mode");
  AST_CLK_OE: assert property (st |-> serial_clk_pin_oe == (mode_r[0] && !ctrl_r[1]))
    else $error("clock pin direction wrong");
  AST_CLK_LOW: assert property ($fell(serial_clk_pin_oe) |-> $past(serial_clk_pin_o) == 1'b0)
    else $error("no low cycle before clock release");
  cover property (wr && aa_r == `SCU_OFF_TXD);
  cover property ($fell(serial_clk_pin_oe));
  cover property (st && !te && serial_out_pin_oe);
endmodule : scu_top_asserts
bind scu_top scu_top_asserts i_scu_top_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .serial_in_pin(serial_in_pin), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe(serial_out_pin_oe), .serial_clk_pin_i(serial_clk_pin_i),
  .serial_clk_pin_o(serial_clk_pin_o), .serial_clk_pin_oe(serial_clk_pin_oe));

// ### verif/scu_far_model.sv
/*
  Remote asynchronous transceiver: 8N1, LSB first, one bit per BIT clocks.
  Assumes the line has a pull-up, so a released line reads high.
*/
`timescale 1ns/10ps
module scu_far_model #(
  parameter int BIT = 64
) (
  input wire logic hclk,
  input wire logic line_o,
  input wire logic line_oe,
  output logic line_in
);
  // ----------
  // Line and frames
  // ----------
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  logic ln;
  assign ln = line_oe ? line_o : 1'b1;
  initial line_in = 1'b1;
  // A zero stop bit is sent only where a test asks for a framing fault.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_in <= f[i];
      repeat (BIT) @(posedge hclk);
    end
    line_in <= 1'b1;
  endtask : send
  initial begin
    forever begin
      @(posedge hclk);
      if (ln === 1'b0) begin
        repeat (BIT / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge hclk);
          sh[i] = ln;
        end
        repeat (BIT) @(posedge hclk);
        rx_q.push_back(sh);
      end
    end
  end
endmodule : scu_far_model

// ### verif/tb_top.sv
/*
  Self-checking bench of the serial unit: bus tasks and test sequences.
  Assumes the far model at the reset baud setting.
*/
`timescale 1ns/10ps
`include "scu_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  // ----------
  // Harness
  // ----------
  localparam int BITC = 16 * (`SCU_BAUD_RST + 1);
  logic hclk, hresetn, hsel, hwrite, sin, hreadyout, hresp, so, soe, co, coe;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  int bad_count, tests_run;
  scu_top i_scu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(sin),
    .serial_out_pin_o(so), .serial_out_pin_oe(soe), .serial_clk_pin_i(1'b1),
    .serial_clk_pin_o(co), .serial_clk_pin_oe(coe));
  scu_far_model #(.BIT(BITC)) i_scu_far_model (.hclk(hclk), .line_o(so), .line_oe(soe),
    .line_in(sin));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
  endtask : wait_rdy
  // One single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'b10, w, a, 3'b010};
    wait_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, `SCU_OFF_STAT, 32'h0);
      n++;
    end while (rd[b] !== v && n < 600);
    `CHK(rd[b], v)
  endtask : poll
  task automatic wait_rx(input int k);
    for (int n = 0; n < 4000 && i_scu_far_model.rx_q.size() < k; n++) @(posedge hclk);
    `CHK(i_scu_far_model.rx_q.size(), k)
  endtask : wait_rx
  task automatic stat();
    bus(1'b0, `SCU_OFF_STAT, 32'h0);
  endtask : stat
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    final_report();
  end
  // ----------
  // Tests
  // ----------
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    stat();
    `CHK(rd[7], 1'b1)
    `CHK(rd[6:3], 4'h0)
    bus(1'b0, `SCU_OFF_BAUD, 32'h0);
    `CHK(rd, 32'h0000_0003)
    bus(1'b1, 12'h01c, 32'h0000_00ff);
    bus(1'b0, 12'h01c, 32'h0);
    `CHK(rd, 32'h0000_0000)
    $display("test map done");
    bus(1'b1, `SCU_OFF_CTRL, 32'h80);
    bus(1'b1, `SCU_OFF_TXD, 32'h55);
    poll(7, 1'b1);
    bus(1'b1, `SCU_OFF_TXD, 32'ha3);
    stat();
    `CHK(rd[7], 1'b0)
    bus(1'b1, `SCU_OFF_TXD, 32'h3c);
    wait_rx(2);
    `CHK(i_scu_far_model.rx_q[0], 8'h55)
    `CHK(i_scu_far_model.rx_q[1], 8'h3c)
    $display("test transmit done");
    bus(1'b1, `SCU_OFF_PORT, 32'h3);
    bus(1'b1, `SCU_OFF_TXD, 32'h0f);
    repeat (100) @(posedge hclk);
    bus(1'b1, `SCU_OFF_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK({soe, so}, 2'b11)
    bus(1'b1, `SCU_OFF_PORT, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK(soe, 1'b0)
    repeat (800) @(posedge hclk);
    i_scu_far_model.rx_q.delete();
    $display("test abort done");
    bus(1'b1, `SCU_OFF_CTRL, 32'h40);
    i_scu_far_model.send(8'ha5, 1'b1);
    poll(6, 1'b1);
    bus(1'b0, `SCU_OFF_RXD, 32'h0);
    `CHK(rd[7:0], 8'ha5)
    stat();
    `CHK(rd[6], 1'b0)
    i_scu_far_model.send(8'h11, 1'b1);
    i_scu_far_model.send(8'h22, 1'b1);
    repeat (100) @(posedge hclk);
    stat();
    `CHK(rd[6:5], 2'b11)
    bus(1'b0, `SCU_OFF_RXD, 32'h0);
    `CHK(rd[7:0], 8'h11)
    stat();
    `CHK(rd[6], 1'b0)
    i_scu_far_model.send(8'h33, 1'b1);
    repeat (100) @(posedge hclk);
    stat();
    `CHK(rd[6], 1'b0)
    $display("test receive done");
    bus(1'b1, `SCU_OFF_MODE, 32'h1);
    bus(1'b1, `SCU_OFF_CTRL, 32'h80);
    bus(1'b1, `SCU_OFF_TXD, 32'h96);
    `CHK(coe, 1'b1)
    repeat (300) @(posedge hclk);
    stat();
    `CHK(rd[7], 1'b0)
    `CHK(rd[5], 1'b1)
    bus(1'b1, `SCU_OFF_STAT, 32'hff);
    bus(1'b1, `SCU_OFF_STAT, 32'hdf);
    stat();
    `CHK(rd[5], 1'b1)
    bus(1'b1, `SCU_OFF_STAT, 32'hdf);
    stat();
    `CHK(rd[5], 1'b0)
    poll(7, 1'b1);
    poll(2, 1'b1);
    bus(1'b1, `SCU_OFF_CTRL, 32'h02);
    @(posedge hclk);
    @(negedge hclk);
    `CHK({coe, co}, 2'b10)
    repeat (3) @(posedge hclk);
    `CHK(coe, 1'b0)
    bus(1'b1, `SCU_OFF_MODE, 32'h0);
    bus(1'b1, `SCU_OFF_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK(coe, 1'b0)
    $display("test sync done");
    bus(1'b1, `SCU_OFF_CTRL, 32'h40);
    i_scu_far_model.send(8'h5a, 1'b0);
    repeat (100) @(posedge hclk);
    stat();
    `CHK(rd[4], 1'b1)
    bus(1'b0, `SCU_OFF_RXD, 32'h0);
    `CHK(rd[7:0], 8'h5a)
    bus(1'b1, `SCU_OFF_MODE, 32'h4);
    bus(1'b1, `SCU_OFF_CTRL, 32'h80);
    repeat (3) @(posedge hclk);
    `CHK(soe, 1'b0)
    bus(1'b1, `SCU_OFF_MODE, 32'hc);
    repeat (3) @(posedge hclk);
    `CHK(soe, 1'b1)
    $display("test framing and low power done");
    final_report();
  end
endmodule : tb_top
